// ===== design/ufc_pkg.sv
`default_nettype none
package ufc_pkg;
  // Storage geometry
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W     = 8;
  localparam int CNT_W      = $clog2(FIFO_DEPTH) + 1;
  localparam int PTR_W      = $clog2(FIFO_DEPTH);

  // Register offsets on the plain register port
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] OFS_SETUP = 3'h0; // fifo_setup
  localparam logic [ADDR_W-1:0] OFS_CAUSE = 3'h1; // interrupt_cause_register
  localparam logic [ADDR_W-1:0] OFS_TXHR  = 3'h2; // tx_holding_reg, write
  localparam logic [ADDR_W-1:0] OFS_RXHR  = 3'h3; // rx_holding_reg, read
  localparam logic [ADDR_W-1:0] OFS_LEVEL = 3'h4; // receive fill level
  localparam logic [ADDR_W-1:0] OFS_ISTS  = 3'h5; // sticky events, W1C
  localparam logic [ADDR_W-1:0] OFS_IMSK  = 3'h6; // event mask

  // fifo_setup field positions
  localparam int SET_EN     = 0;
  localparam int SET_RXRST  = 1;
  localparam int SET_TXRST  = 2;
  localparam int SET_DMA    = 3;
  localparam int SET_TRG_LO = 6;
  localparam int SET_TRG_HI = 7;

  // Sticky event bits
  localparam int EV_RXTRG = 0;
  localparam int EV_TOUT  = 1;
  localparam int EV_TXMT  = 2;
  localparam int EV_OVR   = 3;
  localparam int EV_W     = 4;

  // Interrupt cause codes, bits 3:0
  localparam logic [3:0] CAUSE_NONE = 4'h1;
  localparam logic [3:0] CAUSE_RXDA = 4'h4;
  localparam logic [3:0] CAUSE_TOUT = 4'hC;

  // Reset values
  localparam logic [1:0]      RST_TRG  = 2'h0;
  localparam logic [EV_W-1:0] RST_IMSK = 4'h0;

  // Trigger levels in bytes
  localparam logic [CNT_W-1:0] TRG_1  = 5'h01;
  localparam logic [CNT_W-1:0] TRG_4  = 5'h04;
  localparam logic [CNT_W-1:0] TRG_8  = 5'h08;
  localparam logic [CNT_W-1:0] TRG_14 = 5'h0E;

  // Receive time-out: four character times
  localparam int CLK_PERIOD_NS = 20;
  localparam int CHAR_TIME_NS  = 86800;
  localparam int TOUT_CHARS    = 4;
  localparam int TOUT_CYCLES_DEF =
    (TOUT_CHARS * CHAR_TIME_NS) / CLK_PERIOD_NS;

  // Trigger code to byte count
  function automatic logic [CNT_W-1:0] trig_bytes(input logic [1:0] code);
    case (code)
      2'h0:    trig_bytes = TRG_1;
      2'h1:    trig_bytes = TRG_4;
      2'h2:    trig_bytes = TRG_8;
      default: trig_bytes = TRG_14;
    endcase
  endfunction : trig_bytes
endpackage : ufc_pkg
`default_nettype wire

// ===== design/ufc_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ufc_fifo_if;
  import ufc_pkg::*;
  logic                push;  // Store pdata
  logic [DATA_W-1:0]   pdata; // Byte to store
  logic                pop;   // Drop oldest byte
  logic                flush; // Empty storage and counters
  logic [DATA_W-1:0]   rdata; // Oldest byte
  logic [CNT_W-1:0]    count; // Bytes held

  modport owner (output push, pdata, pop, flush, input rdata, count);
  modport store (input push, pdata, pop, flush, output rdata, count);
endinterface : ufc_fifo_if
`default_nettype wire

// ===== design/ufc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_fifo
  import ufc_pkg::*;
  (
  input wire logic   core_clk, // System clock
  input wire logic   resetn,   // Synchronous reset, active low
  ufc_fifo_if.store  fif       // Storage port
);
  logic [DATA_W-1:0] mem_q [FIFO_DEPTH];
  logic [PTR_W-1:0]  wptr_q;
  logic [PTR_W-1:0]  rptr_q;
  logic [CNT_W-1:0]  cnt_q;
  wire               do_push;
  wire               do_pop;

  // Guarded strobes
  assign do_push = fif.push && (cnt_q != CNT_W'(FIFO_DEPTH));
  assign do_pop  = fif.pop && (cnt_q != '0);
  assign fif.rdata = mem_q[rptr_q];
  assign fif.count = cnt_q;

  // Pointers and fill count
  always_ff @(posedge core_clk) begin
    if (!resetn || fif.flush) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else begin
      if (do_push) wptr_q <= wptr_q + PTR_W'(1);
      if (do_pop)  rptr_q <= rptr_q + PTR_W'(1);
      cnt_q <= cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  // Byte storage
  always_ff @(posedge core_clk) begin
    if (do_push) mem_q[wptr_q] <= fif.pdata;
  end

  depth_bound_a: assert property (
    @(posedge core_clk) disable iff (!resetn)
    cnt_q <= CNT_W'(FIFO_DEPTH)) else $error("fill count over depth");
endmodule : ufc_fifo
`default_nettype wire

// ===== design/ufc_top.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_top
  import ufc_pkg::*;
  #(
  parameter int TOUT_CYCLES = TOUT_CYCLES_DEF
) (
  input  wire logic              core_clk,         // 50 MHz clock
  input  wire logic              resetn,           // Sync reset, low
  input  wire logic [ADDR_W-1:0] reg_addr,         // Register offset
  input  wire logic [DATA_W-1:0] reg_wdata,        // Write data
  input  wire logic              reg_we,           // Write strobe
  input  wire logic              reg_re,           // Read strobe
  output logic      [DATA_W-1:0] reg_rdata,        // Read data, next cycle
  output logic                   irq,              // Level interrupt
  input  wire logic              tx_take,          // Shifter takes byte
  output logic      [DATA_W-1:0] tx_byte,          // Oldest transmit byte
  output logic                   tx_byte_valid,    // Transmit byte held
  input  wire logic              rx_put,           // Shifter delivers byte
  input  wire logic [DATA_W-1:0] rx_byte,          // Received byte
  output logic                   tx_space_ready_n, // Transmit pin
  output logic                   rx_data_ready_n   // Receive pin
);
  localparam int TW = $clog2(TOUT_CYCLES + 1);

  // All checks run on the core clock, quiet in reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  ufc_fifo_if txf ();
  ufc_fifo_if rxf ();

  ufc_fifo u_tx (
    .core_clk (core_clk),
    .resetn   (resetn),
    .fif      (txf)
  );
  ufc_fifo u_rx (
    .core_clk (core_clk),
    .resetn   (resetn),
    .fif      (rxf)
  );

  logic              en_q;
  logic              dma_q;
  logic [1:0]        trg_q;
  logic [EV_W-1:0]   ists_q;
  logic [EV_W-1:0]   imsk_q;
  logic [DATA_W-1:0] rdata_q;
  logic              txp_q;
  logic              rxp_q;
  logic              lvl_q;
  logic              tout_q;
  logic [TW-1:0]     tcnt_q;
  logic              txp_d;
  logic              rxp_d;

  // Register port decode
  wire wr_setup = reg_we && (reg_addr == OFS_SETUP);
  wire wr_txhr  = reg_we && (reg_addr == OFS_TXHR);
  wire wr_ists  = reg_we && (reg_addr == OFS_ISTS);
  wire wr_imsk  = reg_we && (reg_addr == OFS_IMSK);
  wire rd_rxhr  = reg_re && (reg_addr == OFS_RXHR);
  wire set_on   = reg_wdata[SET_EN];
  wire en_chg   = wr_setup && (set_on != en_q);

  // Capacity: sixteen with stores on, one holding byte with them off
  wire [CNT_W-1:0] cap = en_q ? CNT_W'(FIFO_DEPTH) : CNT_W'(1);
  wire tx_full  = (txf.count == cap);
  wire rx_full  = (rxf.count == cap);
  wire tx_empty = (txf.count == '0);
  wire rx_empty = (rxf.count == '0);

  // Receive trigger decode
  wire [CNT_W-1:0] trg_cnt = trig_bytes(trg_q);
  wire lvl_hit = en_q && (rxf.count >= trg_cnt);
  wire mode1   = en_q && dma_q;

  // Store strobes; flush on reset bits written with bit 0 set and on any enable change
  assign txf.push  = wr_txhr && !tx_full;
  assign txf.pdata = reg_wdata;
  assign txf.pop   = tx_take;
  assign txf.flush = (wr_setup && set_on && reg_wdata[SET_TXRST])
                     || en_chg;
  assign rxf.push  = rx_put && !rx_full;
  assign rxf.pdata = rx_byte;
  assign rxf.pop   = rd_rxhr;
  assign rxf.flush = (wr_setup && set_on && reg_wdata[SET_RXRST])
                     || en_chg;

  // fifo_setup: bit 0 always, others only with bit 0 set
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      en_q  <= 1'b0;
      dma_q <= 1'b0;
      trg_q <= RST_TRG;
    end else if (wr_setup) begin
      en_q <= set_on;
      if (set_on) begin
        dma_q <= reg_wdata[SET_DMA];
        trg_q <= reg_wdata[SET_TRG_HI:SET_TRG_LO];
      end
    end
  end

  // Time-out counter runs while bytes sit below trigger, idle
  wire t_run  = en_q && !rx_empty && !lvl_hit && !rx_put && !rd_rxhr;
  wire t_done = (tcnt_q == TW'(TOUT_CYCLES - 1));
  always_ff @(posedge core_clk) begin
    if (!resetn || !t_run) begin
      tcnt_q <= '0;
    end else if (!t_done) begin
      tcnt_q <= tcnt_q + TW'(1);
    end
  end
  always_ff @(posedge core_clk) begin
    if (!resetn || rx_empty || rd_rxhr || !en_q) begin
      tout_q <= 1'b0;
    end else if (t_run && t_done) begin
      tout_q <= 1'b1;
    end
  end

  // Pin next values per signalling mode
  always_comb begin
    txp_d = txp_q;
    rxp_d = rxp_q;
    if (!mode1) begin
      txp_d = !tx_empty;
      rxp_d = rx_empty;
    end else begin
      if (tx_full) begin
        txp_d = 1'b1;
      end else if (tx_empty) begin
        txp_d = 1'b0;
      end
      if (rx_empty) begin
        rxp_d = 1'b1;
      end else if (lvl_hit || tout_q) begin
        rxp_d = 1'b0;
      end
    end
  end

  // Registered pins and level history
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      txp_q <= 1'b0;
      rxp_q <= 1'b1;
      lvl_q <= 1'b0;
    end else begin
      txp_q <= txp_d;
      rxp_q <= rxp_d;
      lvl_q <= lvl_hit;
    end
  end
  assign tx_space_ready_n = txp_q;
  assign rx_data_ready_n  = rxp_q;
  assign tx_byte          = txf.rdata;
  assign tx_byte_valid    = !tx_empty;

  // Events into sticky status; set wins over clear
  wire [EV_W-1:0] ev;
  assign ev[EV_RXTRG] = lvl_hit && !lvl_q;
  assign ev[EV_TOUT]  = t_run && t_done && !tout_q;
  assign ev[EV_TXMT]  = tx_take && (txf.count == CNT_W'(1));
  assign ev[EV_OVR]   = rx_put && rx_full;
  wire [EV_W-1:0] clr = wr_ists ? reg_wdata[EV_W-1:0] : '0;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ists_q <= '0;
      imsk_q <= RST_IMSK;
    end else begin
      ists_q <= (ists_q & ~clr) | ev;
      if (wr_imsk) imsk_q <= reg_wdata[EV_W-1:0];
    end
  end
  assign irq = |(ists_q & imsk_q);

  // Cause code and read mux
  wire [3:0] cause = !en_q    ? CAUSE_NONE :
                     tout_q   ? CAUSE_TOUT :
                     lvl_hit  ? CAUSE_RXDA : CAUSE_NONE;
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      OFS_SETUP: begin
        rd_mux[SET_EN]                = en_q;
        rd_mux[SET_DMA]               = dma_q;
        rd_mux[SET_TRG_HI:SET_TRG_LO] = trg_q;
      end
      OFS_CAUSE: rd_mux = {{2{en_q}}, 2'h0, cause};
      OFS_RXHR:  rd_mux = rxf.rdata;
      OFS_LEVEL: rd_mux = {3'h0, rxf.count};
      OFS_ISTS:  rd_mux = {4'h0, ists_q};
      OFS_IMSK:  rd_mux = {4'h0, imsk_q};
      default:   rd_mux = '0;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (reg_re) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= '0;
    end
  end
  assign reg_rdata = rdata_q;

  // Checks: setup writes and one-cycle-later results
  sequence s_setup_wr(logic [DATA_W-1:0] m);
    wr_setup && ((reg_wdata & m) == m);
  endsequence
  sequence s_empty_next(logic c);
    ##1 (c == 1'b0);
  endsequence

  // Receive trigger and fill
  rx_irq_rise_a: assert property (
    (lvl_hit && !lvl_q) |=> ists_q[EV_RXTRG])
    else $error("trigger event not latched");
  rx_accept_a: assert property (
    (rx_put && en_q && !rx_full && !rd_rxhr && !rxf.flush)
    |=> (rxf.count == $past(rxf.count) + CNT_W'(1)))
    else $error("byte below full not stored");
  trig_code_a: assert property (
    (en_q && trg_q == 2'h3 && rxf.count == 5'h0D) |-> !lvl_hit)
    else $error("level 14 hit at 13 bytes");
  cause_drop_a: assert property (
    (reg_re && reg_addr == OFS_CAUSE && en_q && !tout_q
     && (rxf.count < trg_cnt)) |=> (reg_rdata[3:0] == CAUSE_NONE))
    else $error("receive cause held below trigger");

  // Setup register
  trg_wr_a: assert property (
    s_setup_wr(8'h01) |=> (trg_q == $past(reg_wdata[SET_TRG_HI:SET_TRG_LO])))
    else $error("trigger field not taken");
  dma_default_a: assert property (
    $rose(resetn) |-> (!dma_q && !en_q))
    else $error("setup not cleared by reset");
  off_cap_a: assert property (
    !en_q |-> (txf.count <= CNT_W'(1) && rxf.count <= CNT_W'(1)))
    else $error("store holds more than one byte while off");
  gated_wr_a: assert property (
    (wr_setup && !set_on) |=> ($stable(trg_q) && $stable(dma_q) && !en_q))
    else $error("setup bits changed without enable");
  flush_rd_a: assert property (
    (reg_re && reg_addr == OFS_SETUP)
    |=> (reg_rdata[SET_TXRST] == 1'b0 && reg_rdata[SET_RXRST] == 1'b0))
    else $error("reset bits read back set");
  tx_flush_a: assert property (
    s_setup_wr(8'h05) |-> s_empty_next(|txf.count))
    else $error("transmit store not emptied");
  rx_flush_a: assert property (
    s_setup_wr(8'h03) |-> s_empty_next(|rxf.count))
    else $error("receive store not emptied");
  isr_top_a: assert property (
    (reg_re && reg_addr == OFS_CAUSE) |=> (reg_rdata[7:6] == {2{en_q}}))
    else $error("cause top bits wrong");

  // Pins
  tx_mode0_a: assert property (
    !mode1 |=> (tx_space_ready_n == !$past(tx_empty)))
    else $error("transmit pin wrong in mode zero");
  rx_mode0_a: assert property (
    !mode1 |=> (rx_data_ready_n == $past(rx_empty)))
    else $error("receive pin wrong in mode zero");
  tx_mode1_a: assert property (
    (mode1 && tx_full) |=> tx_space_ready_n)
    else $error("transmit pin low while full");
  tx_mode1_mt_a: assert property (
    (mode1 && tx_empty) |=> !tx_space_ready_n)
    else $error("transmit pin high while empty");
  rx_mode1_a: assert property (
    (mode1 && !rx_empty && lvl_hit) |=> !rx_data_ready_n)
    else $error("receive pin high at trigger");
  rx_mode1_mt_a: assert property (
    (mode1 && rx_empty) |=> rx_data_ready_n)
    else $error("receive pin low while empty");

  // Time-out
  tout_set_a: assert property (
    (t_run && t_done) |=> tout_q)
    else $error("time-out not flagged");
endmodule : ufc_top
`default_nettype wire

// ===== design/ufc_pkg_dummy_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== verif/ufc_shifter_model.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_shifter_model
  import ufc_pkg::*;
(
  input  wire logic              core_clk,      // Clock
  input  wire logic              tx_byte_valid, // Byte held
  input  wire logic [DATA_W-1:0] tx_byte,       // Oldest byte
  output logic                   tx_take,       // Take pulse
  output logic                   rx_put,        // Deliver pulse
  output logic      [DATA_W-1:0] rx_byte        // Delivered byte
);
  logic              drain;  // Bench stalls or drains
  logic [DATA_W-1:0] got[$]; // Bytes taken
  // Idle values
  initial begin
    drain   = 1'b0;
    tx_take = 1'b0;
    rx_put  = 1'b0;
    rx_byte = 8'hA5;
  end
  // Take every other cycle so the count settles first
  always @(posedge core_clk) begin
    if (tx_take) got.push_back(tx_byte);
    tx_take <= drain && tx_byte_valid && !tx_take;
  end
  // One received byte; line scrambled when idle
  task automatic send(input logic [DATA_W-1:0] b);
    @(posedge core_clk);
    rx_put  <= 1'b1;
    rx_byte <= b;
    @(posedge core_clk);
    rx_put  <= 1'b0;
    rx_byte <= ~b;
  endtask : send
endmodule : ufc_shifter_model
`default_nettype wire

// ===== verif/uart_fifo_control_dma_ready_bench.sv
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_control_dma_ready_bench;
  import ufc_pkg::*;
  localparam int TOUT = 20;
  logic              core_clk, resetn, reg_we, reg_re, irq;
  logic              tx_take, rx_put, txv, txn, rxn;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, tx_byte, rx_byte, d;
  logic [DATA_W-1:0] txq[$], rxq[$];
  int                bad_count, checks, cap;
  int                tl[4] = '{1, 4, 8, 14};

  ufc_top #(.TOUT_CYCLES(TOUT)) dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .irq(irq), .tx_take(tx_take),
    .tx_byte(tx_byte), .tx_byte_valid(txv), .rx_put(rx_put),
    .rx_byte(rx_byte), .tx_space_ready_n(txn), .rx_data_ready_n(rxn));
  ufc_shifter_model sh (
    .core_clk(core_clk), .tx_byte_valid(txv), .tx_byte(tx_byte),
    .tx_take(tx_take), .rx_put(rx_put), .rx_byte(rx_byte));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] v);
    @(posedge core_clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_we    <= 1'b0;
  endtask : wr
  task automatic rd(logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic put();
    logic [7:0] b;
    b = 8'($urandom);
    sh.send(b);
    if (rxq.size() < cap) rxq.push_back(b);
  endtask : put
  task automatic txw();
    logic [7:0] b;
    b = 8'($urandom);
    wr(OFS_TXHR, b);
    if (txq.size() < cap) txq.push_back(b);
  endtask : txw
  task automatic popc();
    rd(OFS_RXHR);
    chk("rx byte", rxq.pop_front(), d);
  endtask : popc
  task automatic drain_tx();
    sh.drain = 1'b1;
    for (int k = 0; k < 200 && txv !== 1'b0; k++) @(posedge core_clk);
    settle();
    sh.drain = 1'b0;
    chk("tx taken", 8'(txq.size()), 8'(sh.got.size()));
    while (txq.size() && sh.got.size())
      chk("tx byte", txq.pop_front(), sh.got.pop_front());
  endtask : drain_tx
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // Watchdog
  initial begin
    #400000;
    bad_count++;
    close_out();
  end

  // Main sequence
  initial begin
    {resetn, reg_we, reg_re, reg_addr, reg_wdata} = '0;
    void'($urandom(93));
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rd(OFS_SETUP); chk("setup", 8'h00, d);
    rd(OFS_CAUSE); chk("cause", 8'h01, d);
    settle(); chk("txpin", 8'h00, {7'h0, txn});
    chk("rxpin", 8'h01, {7'h0, rxn});
    // Disabled: one byte each way
    cap = 1;
    put(); settle(); chk("rxpin", 8'h00, {7'h0, rxn});
    popc(); settle(); chk("rxpin", 8'h01, {7'h0, rxn});
    txw(); settle(); chk("txpin", 8'h01, {7'h0, txn});
    drain_tx(); chk("txpin", 8'h00, {7'h0, txn});
    // Field writes need bit 0
    wr(OFS_SETUP, 8'hC9); rd(OFS_SETUP); chk("setup", 8'hC9, d);
    rd(OFS_CAUSE); chk("cause", 8'hC1, d);
    wr(OFS_SETUP, 8'h00); rd(OFS_SETUP); chk("setup", 8'hC8, d);
    // Every trigger code
    cap = 16;
    wr(OFS_IMSK, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SETUP, {2'(i), 6'h03});
      rxq.delete();
      repeat (tl[i] - 1) put();
      rd(OFS_CAUSE); chk("cause", 8'hC1, d);
      put();
      rd(OFS_CAUSE); chk("cause", 8'hC4, d);
      chk("irq", 8'h01, {7'h0, irq});
      rd(OFS_LEVEL); chk("level", 8'(tl[i]), d);
      popc();
      rd(OFS_CAUSE); chk("cause", 8'hC1, d);
      wr(OFS_ISTS, 8'h0F);
      @(posedge core_clk);
      #1 chk("irq", 8'h00, {7'h0, irq});
    end
    // Fill past full
    wr(OFS_SETUP, 8'h03);
    rxq.delete();
    repeat (17) put();
    rd(OFS_LEVEL); chk("level", 8'h10, d);
    rd(OFS_ISTS); chk("overrun", 8'h01, {7'h0, d[EV_OVR]});
    repeat (16) popc();
    // Mode one receive, trigger four
    wr(OFS_SETUP, 8'h4B);
    repeat (3) put();
    settle(); chk("rxpin", 8'h01, {7'h0, rxn});
    put(); settle(); chk("rxpin", 8'h00, {7'h0, rxn});
    repeat (3) popc();
    settle(); chk("rxpin", 8'h00, {7'h0, rxn});
    popc(); settle(); chk("rxpin", 8'h01, {7'h0, rxn});
    put();
    repeat (TOUT + 8) @(posedge core_clk);
    #1 chk("rxpin", 8'h00, {7'h0, rxn});
    rd(OFS_CAUSE); chk("cause", 8'hCC, d);
    rd(OFS_ISTS); chk("tout event", 8'h01, {7'h0, d[EV_TOUT]});
    popc(); settle(); chk("rxpin", 8'h01, {7'h0, rxn});
    // Mode one transmit
    wr(OFS_SETUP, 8'h0D);
    txw(); settle(); chk("txpin", 8'h00, {7'h0, txn});
    repeat (16) txw();
    settle(); chk("txpin", 8'h01, {7'h0, txn});
    drain_tx(); chk("txpin", 8'h00, {7'h0, txn});
    rd(OFS_ISTS); chk("tx empty event", 8'h01, {7'h0, d[EV_TXMT]});
    // Mode zero transmit, then flushes
    wr(OFS_SETUP, 8'h01);
    txw(); settle(); chk("txpin", 8'h01, {7'h0, txn});
    wr(OFS_SETUP, 8'h05);
    txq.delete();
    settle(); chk("txvalid", 8'h00, {7'h0, txv});
    chk("txpin", 8'h00, {7'h0, txn});
    rd(OFS_SETUP); chk("setup", 8'h01, d);
    put(); put(); wr(OFS_SETUP, 8'h03);
    rxq.delete();
    settle(); chk("rxpin", 8'h01, {7'h0, rxn});
    rd(OFS_LEVEL); chk("level", 8'h00, d);
    // Reset in mid-run clears setup, status and pins
    wr(OFS_SETUP, 8'hC9);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rd(OFS_SETUP); chk("setup", 8'h00, d);
    rd(OFS_ISTS); chk("status", 8'h00, d);
    chk("irq", 8'h00, {7'h0, irq});
    settle(); chk("rxpin", 8'h01, {7'h0, rxn});
    chk("txpin", 8'h00, {7'h0, txn});
    rd(3'h7); chk("unmapped", 8'h00, d);
    close_out();
  end
endmodule : uart_fifo_control_dma_ready_bench
`default_nettype wire
